// ---- design/card_byte_fifo.v ----
`timescale 1ns/100ps
`include "card_regs_map.vh"

module card_byte_fifo
(
  // Clock and reset
  input  wire       clk,
  input  wire       rst_n,
  // Write side
  input  wire       wr_en,
  input  wire [7:0] wr_data,
  // Read side
  input  wire       rd_en,
  output reg  [7:0] rd_data,
  // Status
  output wire       full,
  output wire       empty
);

  reg [7:0]              mem [0:15];
  reg [`FIFO_AW:0]       wptr_reg;
  reg [`FIFO_AW:0]       rptr_reg;
  wire [`FIFO_AW:0]      count;

  assign count = wptr_reg - rptr_reg;
  assign full  = (count == `FIFO_DEPTH);
  assign empty = (count == 5'h00);

  always @(posedge clk)
  begin
    if (wr_en && !full)
      mem[wptr_reg[`FIFO_AW-1:0]] <= wr_data;
  end

  always @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      wptr_reg <= 5'h00;
      rptr_reg <= 5'h00;
      rd_data  <= `RST_PORT;
    end
    else
    begin
      if (wr_en && !full)
        wptr_reg <= wptr_reg + 5'h01;
      if (rd_en && !empty)
      begin
        rd_data  <= mem[rptr_reg[`FIFO_AW-1:0]];
        rptr_reg <= rptr_reg + 5'h01;
      end
    end
  end

endmodule

// ---- design/card_host_status_irq_regs.v ----
// Function
// - Busy status follows card busy on data line
// - Transmit: token CRC result sets data CRC
// - Receive: block CRC16 check sets data CRC
// - Data format bit follows token/block format
// - Response CRC7 bit; meaningless when disabled
// - Response format bit follows response format
// - Command FIFO lock while command FIFO not empty or transmit busy
// - Status bits 7 and 6 read zero
// - Busy flag on busy edge, read clears
// - Response done flag, read clears
// - Command done flag, read clears
// - Frame done flag, read clears
// - FIFO B full flag, cleared on empty
// - FIFO A full flag, cleared on empty
// - FIFO B empty flag, cleared on full
// - FIFO A empty flag, cleared on full
// - Set mask bit keeps its flag from the interrupt
// - Command port: read response, write command
// - Interrupt on unmasked flag with global enable
// - CRC disable suppresses response CRC7 check
`timescale 1ns/100ps
`include "card_regs_map.vh"

module card_host_status_irq_regs
(
  // Clock and reset
  input  wire       CLK,
  input  wire       RST_N,
  // Special function register port
  input  wire [7:0] SFR_ADDR,
  input  wire       SFR_WR,
  input  wire       SFR_RD,
  input  wire [7:0] SFR_WDATA,
  output reg  [7:0] SFR_RDATA,
  // Global enable and CRC disable control
  input  wire       IRQ_GLOBAL_EN,
  input  wire       RESPONSE_CRC_DISABLE,
  // Line controller events, same clock
  input  wire       DATA_TX_MODE,
  input  wire       TOKEN_DONE,
  input  wire       TOKEN_CRC_GOOD,
  input  wire       TOKEN_FMT_GOOD,
  input  wire       BLOCK_DONE,
  input  wire       BLOCK_CRC_GOOD,
  input  wire       BLOCK_FMT_GOOD,
  input  wire       RESP_DONE,
  input  wire       RESP_CRC_GOOD,
  input  wire       RESP_FMT_GOOD,
  input  wire       CMD_DONE,
  input  wire       FRAME_DONE,
  input  wire       CMD_TX_BUSY,
  // Card side
  input  wire       CARD_DAT0,
  input  wire       RESP_BYTE_VALID,
  input  wire [7:0] RESP_BYTE,
  input  wire       CMD_BYTE_POP,
  input  wire       DATA_IN_VALID,
  input  wire [7:0] DATA_IN_BYTE,
  input  wire       DATA_OUT_POP,
  // Outputs
  output reg  [7:0] CMD_OUT_BYTE,
  output reg  [7:0] DATA_OUT_BYTE,
  output reg        CARD_CLK,
  output reg        IRQ_REQ
);

  // ********************************************************
  // Address decode
  // ********************************************************
  function hit;
    input [7:0] a;
    input [7:0] b;
    begin
      hit = (a == b);
    end
  endfunction

  wire rd_cmd  = SFR_RD & hit(SFR_ADDR, `ADDR_CMD_PORT);
  wire wr_cmd  = SFR_WR & hit(SFR_ADDR, `ADDR_CMD_PORT);
  wire rd_dat  = SFR_RD & hit(SFR_ADDR, `ADDR_DATA_PORT);
  wire wr_dat  = SFR_WR & hit(SFR_ADDR, `ADDR_DATA_PORT);
  wire rd_flag = SFR_RD & hit(SFR_ADDR, `ADDR_IRQ_FLAGS);
  wire wr_mask = SFR_WR & hit(SFR_ADDR, `ADDR_IRQ_MASK);
  wire wr_div  = SFR_WR & hit(SFR_ADDR, `ADDR_CLK_DIV);

  // ********************************************************
  // Pin synchroniser
  // ********************************************************
  reg busy_s1_reg;
  reg busy_s2_reg;
  reg busy_s3_reg;

  always @(posedge CLK or negedge RST_N)
  begin
    if (!RST_N)
    begin
      busy_s1_reg <= 1'b0;
      busy_s2_reg <= 1'b0;
      busy_s3_reg <= 1'b0;
    end
    else
    begin
      busy_s1_reg <= ~CARD_DAT0;
      busy_s2_reg <= busy_s1_reg;
      busy_s3_reg <= busy_s2_reg;
    end
  end

  wire busy_edge = busy_s2_reg ^ busy_s3_reg;

  // ********************************************************
  // FIFOs
  // ********************************************************
  wire [7:0] resp_rd;
  wire [7:0] cmd_rd;
  wire [7:0] data_a_rd;
  wire [7:0] data_b_rd;
  wire       resp_full;
  wire       resp_empty;
  wire       cmd_full;
  wire       cmd_empty;
  wire       a_full;
  wire       a_empty;
  wire       b_full;
  wire       b_empty;
  reg        wr_sel_reg;
  reg        rd_sel_reg;

  // Card to host: responses
  card_byte_fifo u_resp (
    .clk     (CLK),
    .rst_n   (RST_N),
    .wr_en   (RESP_BYTE_VALID),
    .wr_data (RESP_BYTE),
    .rd_en   (rd_cmd),
    .rd_data (resp_rd),
    .full    (resp_full),
    .empty   (resp_empty)
  );

  // Host to card: command bytes
  card_byte_fifo u_cmd (
    .clk     (CLK),
    .rst_n   (RST_N),
    .wr_en   (wr_cmd),
    .wr_data (SFR_WDATA),
    .rd_en   (CMD_BYTE_POP),
    .rd_data (cmd_rd),
    .full    (cmd_full),
    .empty   (cmd_empty)
  );

  // Data path, two ping-pong FIFOs in the selected direction
  wire a_wr = DATA_TX_MODE ? (wr_dat & ~wr_sel_reg)
                           : (DATA_IN_VALID & ~wr_sel_reg);
  wire b_wr = DATA_TX_MODE ? (wr_dat & wr_sel_reg)
                           : (DATA_IN_VALID & wr_sel_reg);
  wire a_rd = DATA_TX_MODE ? (DATA_OUT_POP & ~rd_sel_reg)
                           : (rd_dat & ~rd_sel_reg);
  wire b_rd = DATA_TX_MODE ? (DATA_OUT_POP & rd_sel_reg)
                           : (rd_dat & rd_sel_reg);
  wire [7:0] a_wdata = DATA_TX_MODE ? SFR_WDATA : DATA_IN_BYTE;

  card_byte_fifo u_fifo_a (
    .clk     (CLK),
    .rst_n   (RST_N),
    .wr_en   (a_wr),
    .wr_data (a_wdata),
    .rd_en   (a_rd),
    .rd_data (data_a_rd),
    .full    (a_full),
    .empty   (a_empty)
  );

  card_byte_fifo u_fifo_b (
    .clk     (CLK),
    .rst_n   (RST_N),
    .wr_en   (b_wr),
    .wr_data (a_wdata),
    .rd_en   (b_rd),
    .rd_data (data_b_rd),
    .full    (b_full),
    .empty   (b_empty)
  );

  // Swap halves when a FIFO fills or drains
  always @(posedge CLK or negedge RST_N)
  begin
    if (!RST_N)
    begin
      wr_sel_reg <= 1'b0;
      rd_sel_reg <= 1'b0;
    end
    else
    begin
      if (wr_sel_reg ? (b_full && !a_full) : (a_full && !b_full))
        wr_sel_reg <= ~wr_sel_reg;
      if (rd_sel_reg ? (b_empty && !a_empty) : (a_empty && !b_empty))
        rd_sel_reg <= ~rd_sel_reg;
    end
  end

  // ********************************************************
  // Status register
  // ********************************************************
  reg [7:0] status_reg;
  reg [7:0] status_next;

  always @*
  begin
    status_next = status_reg;
    status_next[7:6] = 2'b00;
    status_next[`ST_BUSY] = busy_s2_reg;
    if (DATA_TX_MODE && TOKEN_DONE)
    begin
      status_next[`ST_DCRC] = TOKEN_CRC_GOOD;
      status_next[`ST_DFMT] = TOKEN_FMT_GOOD;
    end
    if (!DATA_TX_MODE && BLOCK_DONE)
    begin
      status_next[`ST_DCRC] = BLOCK_CRC_GOOD;
      status_next[`ST_DFMT] = BLOCK_FMT_GOOD;
    end
    if (RESP_DONE)
    begin
      if (!RESPONSE_CRC_DISABLE)
        status_next[`ST_RCRC] = RESP_CRC_GOOD;
      status_next[`ST_RFMT] = RESP_FMT_GOOD;
    end
    status_next[`ST_LOCK] = CMD_TX_BUSY | ~cmd_empty;
  end

  // ********************************************************
  // Interrupt flags and mask
  // ********************************************************
  reg [7:0] flag_reg;
  reg [7:0] flag_next;
  reg [7:0] mask_reg;
  reg       a_full_d_reg;
  reg       a_empty_d_reg;
  reg       b_full_d_reg;
  reg       b_empty_d_reg;
  wire [7:0] set_ev;

  assign set_ev[`FL_BUSY]    = busy_edge;
  assign set_ev[`FL_RESP]    = RESP_DONE;
  assign set_ev[`FL_CMD]     = CMD_DONE;
  assign set_ev[`FL_FRAME]   = FRAME_DONE;
  assign set_ev[`FL_B_FULL]  = b_full & ~b_full_d_reg;
  assign set_ev[`FL_A_FULL]  = a_full & ~a_full_d_reg;
  assign set_ev[`FL_B_EMPTY] = b_empty & ~b_empty_d_reg;
  assign set_ev[`FL_A_EMPTY] = a_empty & ~a_empty_d_reg;

  always @*
  begin
    flag_next = flag_reg;
    if (rd_flag)
      flag_next[7:4] = 4'h0;
    if (b_empty)
      flag_next[`FL_B_FULL] = 1'b0;
    if (a_empty)
      flag_next[`FL_A_FULL] = 1'b0;
    if (b_full)
      flag_next[`FL_B_EMPTY] = 1'b0;
    if (a_full)
      flag_next[`FL_A_EMPTY] = 1'b0;
    flag_next = flag_next | set_ev;
  end

  always @(posedge CLK or negedge RST_N)
  begin
    if (!RST_N)
    begin
      status_reg    <= 8'h00;
      flag_reg      <= 8'h00;
      mask_reg      <= `RST_MASK;
      a_full_d_reg  <= 1'b0;
      a_empty_d_reg <= 1'b1;
      b_full_d_reg  <= 1'b0;
      b_empty_d_reg <= 1'b1;
      IRQ_REQ       <= 1'b0;
    end
    else
    begin
      status_reg    <= status_next;
      flag_reg      <= flag_next;
      a_full_d_reg  <= a_full;
      a_empty_d_reg <= a_empty;
      b_full_d_reg  <= b_full;
      b_empty_d_reg <= b_empty;
      if (wr_mask)
        mask_reg <= SFR_WDATA;
      IRQ_REQ <= IRQ_GLOBAL_EN & |(flag_next & ~mask_reg);
    end
  end

  // ********************************************************
  // Clock divider
  // ********************************************************
  reg [7:0] div_reg;
  reg [7:0] div_cnt_reg;

  always @(posedge CLK or negedge RST_N)
  begin
    if (!RST_N)
    begin
      div_reg     <= `RST_CLK_DIV;
      div_cnt_reg <= 8'h00;
      CARD_CLK    <= 1'b0;
    end
    else
    begin
      if (wr_div)
        div_reg <= SFR_WDATA;
      if (div_cnt_reg >= div_reg)
      begin
        div_cnt_reg <= 8'h00;
        CARD_CLK    <= ~CARD_CLK;
      end
      else
        div_cnt_reg <= div_cnt_reg + 8'h01;
    end
  end

  // ********************************************************
  // Read data and card-side bytes
  // ********************************************************
  reg [7:0] rdata_next;
  reg       rd_fifo_reg;
  reg       rd_is_cmd_reg;

  always @*
  begin
    case (SFR_ADDR)
      `ADDR_LINE_STATUS: rdata_next = status_reg & 8'h3f;
      `ADDR_IRQ_MASK:    rdata_next = mask_reg;
      `ADDR_IRQ_FLAGS:   rdata_next = flag_reg;
      `ADDR_CLK_DIV:     rdata_next = div_reg;
      default:           rdata_next = 8'h00;
    endcase
  end

  always @(posedge CLK or negedge RST_N)
  begin
    if (!RST_N)
    begin
      SFR_RDATA     <= 8'h00;
      rd_fifo_reg   <= 1'b0;
      rd_is_cmd_reg <= 1'b0;
      CMD_OUT_BYTE  <= `RST_PORT;
      DATA_OUT_BYTE <= `RST_PORT;
    end
    else
    begin
      rd_fifo_reg   <= rd_cmd | rd_dat;
      rd_is_cmd_reg <= rd_cmd;
      if (SFR_RD && !(rd_cmd || rd_dat))
        SFR_RDATA <= rdata_next;
      else if (rd_fifo_reg)
        SFR_RDATA <= rd_is_cmd_reg ? resp_rd :
                     (rd_sel_reg ? data_b_rd : data_a_rd);
      CMD_OUT_BYTE  <= cmd_rd;
      DATA_OUT_BYTE <= rd_sel_reg ? data_b_rd : data_a_rd;
    end
  end

endmodule

// ---- design/card_regs_map.vh ----
`ifndef CARD_REGS_MAP_VH
`define CARD_REGS_MAP_VH

// Register addresses on the special function bus
`define ADDR_DATA_PORT   8'hdc
`define ADDR_CMD_PORT    8'hdd
`define ADDR_LINE_STATUS 8'hde
`define ADDR_IRQ_MASK    8'hdf
`define ADDR_IRQ_FLAGS   8'he7
`define ADDR_CLK_DIV     8'hed

// Reset values
`define RST_PORT         8'hff
`define RST_MASK         8'hff
`define RST_CLK_DIV      8'h00

// Status bit positions
`define ST_BUSY          5
`define ST_DCRC          4
`define ST_DFMT          3
`define ST_RCRC          2
`define ST_RFMT          1
`define ST_LOCK          0

// Flag bit positions
`define FL_BUSY          7
`define FL_RESP          6
`define FL_CMD           5
`define FL_FRAME         4
`define FL_B_FULL        3
`define FL_A_FULL        2
`define FL_B_EMPTY       1
`define FL_A_EMPTY       0

// Byte FIFO geometry
`define FIFO_AW          4
`define FIFO_DEPTH       5'h10

`endif

// ---- test/card_host_status_irq_regs_tb_top.sv ----
`timescale 1ns/100ps
`define CHK(g, e) \
  begin \
    check_count++; \
    if ((g) !== (e)) \
    begin \
      fails++; \
      $display("Error at %0t got %h exp %h", $time, g, e); \
    end \
  end
module card_host_status_irq_regs_tb_top;
  // ***
  // Stimulus and checks
  // ***
  logic        clk = 1'h0;
  logic        rst_n = 1'h0;
  logic [7:0]  addr = 8'h00;
  logic        wr = 1'h0;
  logic        rd = 1'h0;
  logic [7:0]  wdata = 8'h00;
  logic        gen = 1'h0;
  logic        txm = 1'h0;
  logic [5:0]  good = 6'h00;
  logic [8:0]  ev = 9'h000;
  logic [7:0]  rbyte = 8'h00;
  logic [7:0]  dbyte = 8'h00;
  logic        busy_req = 1'h0;
  logic        dat0;
  logic [7:0]  rdata;
  logic [7:0]  cmd_out;
  logic        card_clk;
  logic        irq;
  logic        cdis = 1'h0;
  logic        ctb = 1'h0;
  logic [7:0]  dout;
  logic [31:0] rnd = 32'h0000_0284;
  logic [7:0]  v;
  logic [7:0]  q [16];
  int          fails = 0;
  int          check_count = 0;
  int          n;
  always #2 clk = ~clk;
  card_model partner (.busy_req(busy_req), .card_dat0(dat0));
  card_host_status_irq_regs DUT
  (
    .CLK(clk), .RST_N(rst_n), .SFR_ADDR(addr), .SFR_WR(wr), .SFR_RD(rd),
    .SFR_WDATA(wdata), .SFR_RDATA(rdata), .IRQ_GLOBAL_EN(gen),
    .RESPONSE_CRC_DISABLE(cdis), .DATA_TX_MODE(txm),
    .TOKEN_DONE(ev[0]), .TOKEN_CRC_GOOD(good[1]), .TOKEN_FMT_GOOD(good[0]),
    .BLOCK_DONE(ev[1]), .BLOCK_CRC_GOOD(good[3]), .BLOCK_FMT_GOOD(good[2]),
    .RESP_DONE(ev[2]), .RESP_CRC_GOOD(good[5]), .RESP_FMT_GOOD(good[4]),
    .CMD_DONE(ev[3]), .FRAME_DONE(ev[4]), .CMD_TX_BUSY(ctb),
    .CARD_DAT0(dat0), .RESP_BYTE_VALID(ev[5]), .RESP_BYTE(rbyte),
    .CMD_BYTE_POP(ev[6]), .DATA_IN_VALID(ev[7]), .DATA_IN_BYTE(dbyte),
    .DATA_OUT_POP(ev[8]), .CMD_OUT_BYTE(cmd_out), .DATA_OUT_BYTE(dout),
    .CARD_CLK(card_clk), .IRQ_REQ(irq)
  );
  function automatic [31:0] lfsr(input [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  function automatic [7:0] st_exp(input t, input [5:0] g);
    return {3'h0, t ? g[1:0] : g[3:2], g[5:4], 1'h0};
  endfunction
  task tick;
    @(posedge clk);
    #1;
  endtask
  task pulse(input [8:0] m);
    ev = m;
    tick;
    ev = 9'h000;
    tick;
  endtask
  task reg_wr(input [7:0] a, input [7:0] d);
    addr = a;
    wdata = d;
    wr = 1'h1;
    tick;
    wr = 1'h0;
    tick;
  endtask
  task reg_rd(input [7:0] a);
    addr = a;
    rd = 1'h1;
    tick;
    rd = 1'h0;
    tick;
    v = rdata;
  endtask
  task end_of_test;
    $display("Compares %0d mismatches %0d", check_count, fails);
    if (fails == 0 && check_count > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask
  initial
  begin
    #100000;
    fails++;
    end_of_test;
  end
  initial
  begin
    repeat (10) @(posedge clk);
    #1;
    rst_n = 1'h1;
    reg_rd(8'hdf);
    `CHK(v, 8'hff)
    reg_rd(8'h55);
    `CHK(v, 8'h00)
    for (int i = 0; i < 8; i++)
    begin
      rnd = lfsr(rnd);
      good = rnd[5:0];
      txm = rnd[6];
      pulse(txm ? 9'h005 : 9'h006);
      reg_rd(8'hde);
      `CHK(v, st_exp(txm, good))
    end
    n = v[2];
    good[5] = ~v[2];
    cdis = 1'h1;
    pulse(9'h004);
    reg_rd(8'hde);
    `CHK(v[2], n[0])
    cdis = 1'h0;
    busy_req = 1'h1;
    repeat (20) tick;
    reg_rd(8'hde);
    `CHK(v[5], 1'h1)
    reg_rd(8'he7);
    `CHK(v[7], 1'h1)
    reg_rd(8'he7);
    `CHK(v[7:4], 4'h0)
    busy_req = 1'h0;
    repeat (20) tick;
    reg_rd(8'hde);
    `CHK(v[5], 1'h0)
    gen = 1'h1;
    tick;
    `CHK(irq, 1'h0)
    reg_wr(8'hdf, 8'hdf);
    pulse(9'h010);
    `CHK(irq, 1'h0)
    pulse(9'h008);
    `CHK(irq, 1'h1)
    reg_rd(8'he7);
    `CHK(v[5:4], 2'h3)
    tick;
    `CHK(irq, 1'h0)
    rnd = lfsr(rnd);
    reg_wr(8'hdd, rnd[7:0]);
    reg_rd(8'hde);
    `CHK(v[0], 1'h1)
    pulse(9'h040);
    `CHK(cmd_out, rnd[7:0])
    reg_rd(8'hde);
    `CHK(v[0], 1'h0)
    ctb = 1'h1;
    tick;
    reg_rd(8'hde);
    `CHK(v[0], 1'h1)
    ctb = 1'h0;
    rbyte = rnd[15:8];
    pulse(9'h020);
    reg_rd(8'hdd);
    `CHK(v, rnd[15:8])
    txm = 1'h0;
    for (int i = 0; i < 16; i++)
    begin
      rnd = lfsr(rnd);
      dbyte = rnd[7:0];
      q[i] = rnd[7:0];
      pulse(9'h080);
    end
    reg_rd(8'he7);
    `CHK(v[2], 1'h1)
    reg_rd(8'he7);
    `CHK(v[2], 1'h1)
    for (int i = 0; i < 16; i++)
    begin
      reg_rd(8'hdc);
      `CHK(v, q[i])
    end
    reg_rd(8'he7);
    `CHK(v[2:0], 3'h1)
    txm = 1'h1;
    rnd = lfsr(rnd);
    reg_wr(8'hdc, rnd[7:0]);
    pulse(9'h100);
    `CHK(dout, rnd[7:0])
    reg_rd(8'he7);
    `CHK(v[1], 1'h1)
    reg_wr(8'hed, 8'h03);
    for (int k = 0; k < 2; k++)
    begin
      n = 0;
      v[0] = card_clk;
      while (card_clk === v[0] && n < 40)
      begin
        tick;
        n++;
      end
    end
    `CHK(n, 4)
    end_of_test;
  end
endmodule

// ---- test/card_model.sv ----
`timescale 1ns/100ps
module card_model
(
  // Busy request from the bench
  input  wire logic busy_req,
  // Data line zero, pulled up when released
  output logic      card_dat0
);
  // ***
  // Card busy on its own link clock
  // ***
  logic link_clk = 1'h0;
  always #24 link_clk = ~link_clk;
  initial card_dat0 = 1'h1;
  always @(posedge link_clk)
    card_dat0 <= ~busy_req;
endmodule

// ---- test/card_regs_properties.sv ----
`timescale 1ns/100ps
module card_regs_checker
(
  // Clock and reset
  input wire logic       CLK,
  input wire logic       RST_N,
  // Register port
  input wire logic [7:0] SFR_ADDR,
  input wire logic       SFR_WR,
  input wire logic       SFR_RD,
  input wire logic [7:0] SFR_WDATA,
  input wire logic [7:0] SFR_RDATA,
  // Controls and events
  input wire logic       RESPONSE_CRC_DISABLE,
  input wire logic       DATA_TX_MODE,
  input wire logic       TOKEN_DONE,
  input wire logic       TOKEN_CRC_GOOD,
  input wire logic       BLOCK_DONE,
  input wire logic       RESP_DONE,
  input wire logic       RESP_CRC_GOOD,
  input wire logic       RESP_FMT_GOOD,
  input wire logic       CMD_DONE,
  input wire logic       FRAME_DONE,
  input wire logic       CARD_DAT0,
  input wire logic       IRQ_REQ
);
  // ***
  // Checks
  // ***
  logic [7:0] mask_reg;
  default clocking @(posedge CLK); endclocking
  default disable iff (!RST_N);
  always @(posedge CLK or negedge RST_N)
    if (!RST_N)
      mask_reg <= 8'hff;
    else if (SFR_WR && SFR_ADDR == 8'hdf)
      mask_reg <= SFR_WDATA;
  sequence rd_st;
    SFR_RD && SFR_ADDR == 8'hde;
  endsequence
  sequence rd_fl;
    SFR_RD && SFR_ADDR == 8'he7;
  endsequence
  sequence quiet;
    !TOKEN_DONE && !BLOCK_DONE && !RESP_DONE;
  endsequence
  sequence calm;
    $stable(CARD_DAT0) && !CMD_DONE && !FRAME_DONE && !RESP_DONE;
  endsequence
  status_top_zero_a: assert property (rd_st |=> SFR_RDATA[7:6] == 2'h0)
    else $error("Status top bits not zero");
  busy_level_a: assert property ((!CARD_DAT0)[*6] ##0 rd_st |=>
    SFR_RDATA[5]) else $error("Busy status missing");
  resp_crc_a: assert property ((RESP_DONE && !RESPONSE_CRC_DISABLE)
    ##1 quiet[*2] ##0 rd_st |=> SFR_RDATA[2] == $past(RESP_CRC_GOOD, 3))
    else $error("Response crc status wrong");
  resp_fmt_a: assert property (RESP_DONE ##1 quiet[*2] ##0 rd_st |=>
    SFR_RDATA[1] == $past(RESP_FMT_GOOD, 3))
    else $error("Response format status wrong");
  token_crc_a: assert property ((TOKEN_DONE && DATA_TX_MODE) ##1
    quiet[*2] ##0 rd_st |=> SFR_RDATA[4] == $past(TOKEN_CRC_GOOD, 3))
    else $error("Token crc status wrong");
  cmd_flag_set_a: assert property (CMD_DONE ##1 !SFR_RD ##1
    rd_fl |=> SFR_RDATA[5]) else $error("Command done flag missing");
  mask_block_a: assert property (mask_reg == 8'hff &&
    $past(mask_reg) == 8'hff |-> !IRQ_REQ)
    else $error("Interrupt with all masks set");
  flag_clear_a: assert property (calm[*6] ##0 rd_fl ##1 calm[*2] ##0
    rd_fl |=> SFR_RDATA[7:4] == 4'h0) else $error("Flags not cleared");
endmodule
bind card_host_status_irq_regs card_regs_checker u_chk (.*);
